// File: design/tscp_pkg.sv
// package: constants, modes and carriers of the serial port clocking block
package tscp_pkg;

	// ********************************
	// clocking
	// ********************************
	localparam int CORE_KHZ = 50000;
	localparam int REF_KHZ  = 4096;
	localparam int NCO_W    = 16;
	localparam logic [NCO_W-1:0] NCO_INC =
		NCO_W'((REF_KHZ * 65536 + CORE_KHZ / 2) / CORE_KHZ);
	localparam logic [NCO_W-1:0] NCO_RST = 16'h0000;

	// ********************************
	// stream geometry
	// ********************************
	localparam int LINES     = 8;
	localparam int CHANS     = 128;
	localparam int WORD_W    = 64;
	localparam int BUF_DEPTH = 2;
	localparam logic [6:0] CMAX_2M = 7'h1f;
	localparam logic [6:0] CMAX_4M = 7'h3f;
	localparam logic [6:0] CMAX_8M = 7'h7f;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] HIGH_LINES = 8'hf0;

	// ********************************
	// register map
	// ********************************
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] DIR_OFS  = 12'h100;
	localparam logic [11:0] DIR_END  = 12'h2fc;
	localparam int CTRL_W = 8;
	localparam int STAT_W = 13;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

	typedef enum logic [1:0] {
		MODE_ONE, MODE_TWO, MODE_THREE, MODE_FOUR
	} tscp_mode_t;

	typedef enum logic [1:0] {
		RATE_2M, RATE_4M, RATE_8M
	} tscp_rate_t;

	typedef struct packed {
		tscp_mode_t mode;
		logic       ref_sel;
		logic       int_clk;
		tscp_rate_t rate;
		logic       frame_dir_in;
		logic       frame_pol;
	} tscp_ctrl_t;

	typedef struct packed {
		logic       buf_full;
		logic       clk_active;
		logic       frame_idle;
		logic [2:0] bit_idx;
		logic [6:0] chan;
	} tscp_stat_t;

endpackage : tscp_pkg

// File: design/tscp_top.sv
// serial port clocking, framing, per-channel direction and apb registers
// Functional notes
// RQ1: modes two/three drive 4.096 MHz clock out
// RQ2: clock source follows reference and internal selects
// RQ3: active clock out shifts the stream bits
// RQ4: modes one/four tristate clock out automatically
// RQ5: at 8.192 Mbps system supplies reference clock
// RQ6: 32/64/128 channels per stream by rate
// RQ7: 8.192 Mbps uses stream lines zero to three
// RQ8: per-channel line direction, output after reset
// RQ9: reference one high, two low, internal ignores
// RQ10: mode one or 8.192 shifts with reference
// RQ11: frame pulse output with programmable polarity
// RQ12: mode one detects frame input polarity
// RQ13: channels restart at frame, eight bits each
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps

// ********************************
// two-entry word buffer
// ********************************
module tscp_buf #(
	parameter int W = 64,
	parameter int D = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	logic [W-1:0]         mem_r [D];
	logic [$clog2(D)-1:0] wr_r;
	logic [$clog2(D)-1:0] rd_r;
	logic [$clog2(D):0]   cnt_r;
	logic [$clog2(D):0]   cnt_nxt;
	logic                 push;
	logic                 pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_valid_o = (cnt_r != 0);
	assign out_data_o = mem_r[rd_r];
	assign cnt_nxt = cnt_r + {{$clog2(D){1'b0}}, push}
		- {{$clog2(D){1'b0}}, pop};

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			in_ready_o <= 1'b1;
		end else begin
			if (push) begin
				mem_r[wr_r] <= in_data_i;
				wr_r <= (wr_r == D - 1) ? '0 : wr_r + 1'b1;
			end
			if (pop)
				rd_r <= (rd_r == D - 1) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_nxt;
			in_ready_o <= (cnt_nxt != D);
		end
	end
endmodule : tscp_buf

// ********************************
// top
// ********************************
module tscp_top (
	// clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RESETN_I,
	// apb slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// clock references and serial clock out
	input  wire logic        REF_ONE_I,
	input  wire logic        REF_TWO_I,
	output logic             SPCLK_O,
	output logic             SPCLK_OE_N_O,
	// frame pulse pin
	input  wire logic        FRAME_I,
	output logic             FRAME_O,
	output logic             FRAME_OE_N_O,
	// serial stream lines
	input  wire logic [7:0]  STREAM_I,
	output logic      [7:0]  STREAM_O,
	output logic      [7:0]  STREAM_OE_N_O,
	// transmit words, one byte per line
	input  wire logic        TX_VALID_I,
	output logic             TX_READY_O,
	input  wire logic [63:0] TX_DATA_I,
	// received words
	output logic             RX_VALID_O,
	output logic      [63:0] RX_DATA_O
);
	tscp_pkg::tscp_ctrl_t   ctrl_r;
	logic [7:0]             dir_r [tscp_pkg::CHANS];
	logic [1:0]             ref1_sy_r;
	logic [1:0]             ref2_sy_r;
	logic [1:0]             frm_sy_r;
	logic [7:0]             str_sy_r [2];
	logic [15:0]            nco_r;
	logic                   base_lvl;
	logic                   clk_act;
	logic                   direct;
	logic                   top_rate;
	logic                   shift_lvl;
	logic                   sh_prev_r;
	logic                   rise;
	logic                   half_r;
	logic                   bit_en;
	logic [2:0]             frm_hist_r;
	logic                   idle_r;
	logic                   frm_act;
	logic                   frm_prev_r;
	logic                   frm_out_mode;
	logic                   frame_evt;
	logic                   wrap;
	logic [6:0]             chan_max;
	logic [2:0]             bit_r;
	logic [6:0]             chan_r;
	logic [63:0]            tx_sh_r;
	logic [63:0]            rx_sh_r;
	logic [63:0]            rx_nxt;
	logic                   boundary;
	logic                   buf_valid;
	logic [63:0]            buf_data;
	logic                   acc;
	logic                   wr_en;
	logic [11:0]            dir_off;
	logic                   hit_dir;
	tscp_pkg::tscp_stat_t   stat;

	// ********************************
	// pin synchronisers
	// ********************************
	always_ff @(posedge CORE_CLK_I) begin
		ref1_sy_r <= {ref1_sy_r[0], REF_ONE_I};
		ref2_sy_r <= {ref2_sy_r[0], REF_TWO_I};
		frm_sy_r <= {frm_sy_r[0], FRAME_I};
		str_sy_r[0] <= STREAM_I;
		str_sy_r[1] <= str_sy_r[0];
	end

	// ********************************
	// clock source and clock out
	// ********************************
	// the internal clock is an nco: jitter of one core cycle is accepted
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I)
			nco_r <= tscp_pkg::NCO_RST;
		else
			nco_r <= nco_r + tscp_pkg::NCO_INC;
	end

	assign base_lvl = ctrl_r.int_clk ? nco_r[15] :   // RQ9
		(ctrl_r.ref_sel ? ref1_sy_r[1] : ref2_sy_r[1]); // RQ9 RQ2
	assign clk_act = (ctrl_r.mode == tscp_pkg::MODE_TWO) ||
		(ctrl_r.mode == tscp_pkg::MODE_THREE);
	assign direct = (ctrl_r.mode == tscp_pkg::MODE_ONE) ||
		top_rate;
	// both upper rate codes select 8.192, as the channel limit does
	assign top_rate = ctrl_r.rate[1];
	assign shift_lvl = direct ? base_lvl : SPCLK_O; // RQ10 RQ3

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			SPCLK_O <= 1'b0;
			SPCLK_OE_N_O <= 1'b1;
		end else begin
			SPCLK_O <= clk_act ? base_lvl : 1'b0; // RQ1 RQ2
			SPCLK_OE_N_O <= !clk_act; // RQ4
		end
	end

	// ********************************
	// bit timing
	// ********************************
	assign rise = shift_lvl && !sh_prev_r;
	// at 2.048 Mbps two clock periods make one bit
	assign bit_en = rise && (ctrl_r.mode != tscp_pkg::MODE_FOUR) &&
		(ctrl_r.rate != tscp_pkg::RATE_2M || half_r);

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			sh_prev_r <= 1'b0;
			half_r <= 1'b0;
		end else begin
			sh_prev_r <= shift_lvl;
			if (rise)
				half_r <= !half_r;
		end
	end

	// ********************************
	// frame pulse
	// ********************************
	// idle level is learnt from three equal samples, pulses are shorter
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			frm_hist_r <= 3'h0;
			idle_r <= 1'b1;
		end else if (rise) begin
			frm_hist_r <= {frm_hist_r[1:0], frm_sy_r[1]};
			if (frm_hist_r == 3'h0 || frm_hist_r == 3'h7)
				idle_r <= frm_hist_r[0]; // RQ12
		end
	end

	assign frm_act = (ctrl_r.mode == tscp_pkg::MODE_ONE) ?
		(frm_sy_r[1] != idle_r) : // RQ12
		(frm_sy_r[1] == ctrl_r.frame_pol);
	assign frm_out_mode = (ctrl_r.mode == tscp_pkg::MODE_THREE) ||
		(ctrl_r.mode == tscp_pkg::MODE_TWO && !ctrl_r.frame_dir_in);
	assign chan_max = (ctrl_r.rate == tscp_pkg::RATE_2M) ?
		tscp_pkg::CMAX_2M : (ctrl_r.rate == tscp_pkg::RATE_4M) ?
		tscp_pkg::CMAX_4M : tscp_pkg::CMAX_8M; // RQ6
	assign wrap = (bit_r == tscp_pkg::BIT_LAST) && (chan_r == chan_max);
	assign frame_evt = frm_out_mode ? wrap : (frm_act && !frm_prev_r);
	assign boundary = frame_evt || (bit_r == tscp_pkg::BIT_LAST);

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			frm_prev_r <= 1'b0;
			FRAME_O <= 1'b1;
			FRAME_OE_N_O <= 1'b1;
		end else begin
			if (bit_en)
				frm_prev_r <= frm_act;
			FRAME_OE_N_O <= !frm_out_mode; // RQ11
			FRAME_O <= (bit_r == 3'h0 && chan_r == 7'h00) ?
				ctrl_r.frame_pol : !ctrl_r.frame_pol; // RQ11
		end
	end

	// ********************************
	// channel counters and shifters
	// ********************************
	always_comb begin
		rx_nxt = '0;
		for (int l = 0; l < tscp_pkg::LINES; l++)
			rx_nxt[l*8 +: 8] = {rx_sh_r[l*8 +: 7], str_sy_r[1][l]};
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			bit_r <= 3'h0;
			chan_r <= 7'h00;
			tx_sh_r <= '0;
			rx_sh_r <= '0;
			RX_DATA_O <= '0;
			RX_VALID_O <= 1'b0;
		end else begin
			RX_VALID_O <= 1'b0;
			if (bit_en) begin
				rx_sh_r <= rx_nxt;
				if (frame_evt) begin
					bit_r <= 3'h0; // RQ13
					chan_r <= 7'h00; // RQ13
				end else if (bit_r == tscp_pkg::BIT_LAST) begin
					bit_r <= 3'h0;
					chan_r <= (chan_r >= chan_max) ? 7'h00 : chan_r + 7'h01;
				end else begin
					bit_r <= bit_r + 3'h1; // RQ13
				end
				if (bit_r == tscp_pkg::BIT_LAST) begin
					RX_DATA_O <= rx_nxt;
					RX_VALID_O <= 1'b1;
				end
				if (boundary)
					tx_sh_r <= buf_valid ? buf_data : '0;
				else
					for (int l = 0; l < tscp_pkg::LINES; l++)
						tx_sh_r[l*8 +: 8] <= {tx_sh_r[l*8 +: 7], 1'b0};
			end
			// a lower rate set mid-frame must not leave the channel out of range
			if (chan_r > chan_max) begin
				bit_r <= 3'h0; // RQ6
				chan_r <= 7'h00; // RQ6
			end
		end
	end

	// an empty buffer at a channel start sends zeros, the word is not lost
	tscp_buf #(
		.W (tscp_pkg::WORD_W),
		.D (tscp_pkg::BUF_DEPTH)
	) u_buf (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (RESETN_I),
		.in_valid_i  (TX_VALID_I),
		.in_ready_o  (TX_READY_O),
		.in_data_i   (TX_DATA_I),
		.out_valid_o (buf_valid),
		.out_ready_i (bit_en && boundary),
		.out_data_o  (buf_data)
	);

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			STREAM_O <= 8'h00;
			STREAM_OE_N_O <= 8'hff;
		end else begin
			for (int l = 0; l < tscp_pkg::LINES; l++)
				STREAM_O[l] <= tx_sh_r[l*8 + 7];
			STREAM_OE_N_O <= dir_r[chan_r] | // RQ8
				(top_rate ?
				tscp_pkg::HIGH_LINES : 8'h00) | // RQ7
				{8{ctrl_r.mode == tscp_pkg::MODE_FOUR}};
		end
	end

	// ********************************
	// apb registers
	// ********************************
	assign acc = PSEL_I && PENABLE_I;
	assign wr_en = acc && PREADY_O && PWRITE_I && !PSLVERR_O;
	assign dir_off = PADDR_I - tscp_pkg::DIR_OFS;
	assign hit_dir = (PADDR_I >= tscp_pkg::DIR_OFS) &&
		(PADDR_I <= tscp_pkg::DIR_END) && (PADDR_I[1:0] == 2'h0);
	assign stat = '{buf_full: !TX_READY_O, clk_active: clk_act,
		frame_idle: idle_r, bit_idx: bit_r, chan: chan_r};

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
		end else begin
			PREADY_O <= acc && !PREADY_O;
			if (acc && !PREADY_O) begin
				PSLVERR_O <= 1'b0;
				PRDATA_O <= 32'h0000_0000;
				if (PADDR_I == tscp_pkg::CTRL_OFS)
					PRDATA_O <= {24'h00_0000, ctrl_r};
				else if (PADDR_I == tscp_pkg::STAT_OFS)
					PRDATA_O <= {19'h0_0000, stat};
				else if (hit_dir)
					PRDATA_O <= {24'h00_0000, dir_r[dir_off[8:2]]};
				else
					PSLVERR_O <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			ctrl_r <= tscp_pkg::tscp_ctrl_t'(tscp_pkg::CTRL_RST);
			for (int c = 0; c < tscp_pkg::CHANS; c++)
				dir_r[c] <= tscp_pkg::DIR_RST; // RQ8
		end else if (wr_en) begin
			if (PADDR_I == tscp_pkg::CTRL_OFS)
				ctrl_r <= tscp_pkg::tscp_ctrl_t'(PWDATA_I[7:0]);
			else if (hit_dir)
				dir_r[dir_off[8:2]] <= PWDATA_I[7:0]; // RQ8
		end
	end

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);

	clk_drive_a: assert property (clk_act && $stable(ctrl_r) ##1 clk_act
		|-> SPCLK_O == $past(base_lvl) && !SPCLK_OE_N_O) // RQ1
		else $error("clock out not driven from source");
	clk_hiz_a: assert property (!clk_act [*2] |-> SPCLK_OE_N_O && !SPCLK_O) // RQ4
		else $error("clock out not tristated");
	ref_sel_a: assert property (!ctrl_r.int_clk && ctrl_r.ref_sel
		|-> base_lvl == ref1_sy_r[1]) // RQ9
		else $error("reference one not selected");
	int_sel_a: assert property (ctrl_r.int_clk |-> base_lvl == nco_r[15]) // RQ2
		else $error("internal clock not selected");
	shift_src_a: assert property (!direct |-> shift_lvl == SPCLK_O) // RQ3
		else $error("shift clock not clock out");
	direct_src_a: assert property (direct |-> shift_lvl == base_lvl) // RQ10
		else $error("shift clock not reference");
	chan_range_a: assert property ($stable(ctrl_r) [*2] |-> chan_r <= chan_max) // RQ6
		else $error("channel beyond rate limit");
	high_lines_a: assert property (ctrl_r.rate == tscp_pkg::RATE_8M
		|=> STREAM_OE_N_O[7:4] == 4'hf) // RQ7
		else $error("upper lines driven at top rate");
	dir_reset_a: assert property ($rose(RESETN_I) |-> dir_r[chan_r] == 8'h00) // RQ8
		else $error("direction not output after reset");
	frame_restart_a: assert property (bit_en && frame_evt
		|=> bit_r == 3'h0 && chan_r == 7'h00) // RQ13
		else $error("counters not restarted at frame");
	frame_out_a: assert property (frm_out_mode && $stable(ctrl_r)
		|=> !FRAME_OE_N_O ##1 (FRAME_O == ctrl_r.frame_pol)
		== $past(bit_r == 3'h0 && chan_r == 7'h00)) // RQ11
		else $error("frame pulse output wrong");
	apb_ready_a: assert property (acc && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
		else $error("apb answer timing wrong");

	frame_wrap_c: cover property (bit_en && wrap);
	rx_word_c: cover property (RX_VALID_O);
	buf_full_c: cover property (!TX_READY_O ##[1:50] TX_READY_O);
	mode_one_c: cover property (ctrl_r.mode == tscp_pkg::MODE_ONE
		&& bit_en && frame_evt);
endmodule : tscp_top

// File: verification/tscp_far.sv
// far side model: reference clocks, frame pulse and incoming stream lines
`timescale 1ns/100ps

// ********************************
// serial bus partner
// ********************************
module tscp_far (
	// reference enables
	input  wire logic       en_one_i,
	input  wire logic       en_two_i,
	// pins towards the block
	output logic            ref_one_o,
	output logic            ref_two_o,
	output logic            frame_o,
	output logic [7:0]      stream_o
);
	logic base_r;
	int   cnt_r;
	initial begin
		base_r   = 1'b0;
		cnt_r    = 0;
		frame_o  = 1'b1;
		stream_o = 8'h00;
	end
	// 4.096 MHz system reference; a stopped reference stands low
	always #122.1 base_r = ~base_r;
	assign ref_one_o = base_r & en_one_i;
	assign ref_two_o = base_r & en_two_i;
	// 512 reference cycles a frame: 32 channels of 8 bits at 2.048
	always @(posedge base_r) begin
		cnt_r    <= (cnt_r == 511) ? 0 : cnt_r + 1;
		frame_o  <= (cnt_r != 0);
		stream_o <= ~stream_o ^ 8'(cnt_r); // changes every bit
	end
endmodule : tscp_far

// File: verification/tb.sv
// self-checking bench of the serial port clocking block
`timescale 1ns/100ps

// ********************************
// bench top
// ********************************
module tb;
	logic        clk, rst_n, psel, penable, pwrite, en1, en2, txv;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd, PRDATA_O;
	logic        er, PREADY_O, PSLVERR_O, r1, r2, fr, SPCLK_O, SPCLK_OE_N_O;
	logic [7:0]  st, STREAM_O, STREAM_OE_N_O;
	logic        TX_READY_O, RX_VALID_O, foe;
	logic [63:0] RX_DATA_O;
	int          err_count, tests_run, c;

	tscp_far tscp_far_i (.en_one_i(en1), .en_two_i(en2), .ref_one_o(r1),
		.ref_two_o(r2), .frame_o(fr), .stream_o(st));
	tscp_top tscp_top_i (.CORE_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
		.PSLVERR_O(PSLVERR_O), .REF_ONE_I(r1), .REF_TWO_I(r2),
		.SPCLK_O(SPCLK_O), .SPCLK_OE_N_O(SPCLK_OE_N_O), .FRAME_I(fr),
		.FRAME_O(), .FRAME_OE_N_O(foe), .STREAM_I(st), .STREAM_O(STREAM_O),
		.STREAM_OE_N_O(STREAM_OE_N_O), .TX_VALID_I(txv),
		.TX_READY_O(TX_READY_O), .TX_DATA_I(64'h0123_4567_89ab_cdef),
		.RX_VALID_O(RX_VALID_O), .RX_DATA_O(RX_DATA_O));

	always #10 clk = ~clk;

	// ********************************
	// shared tasks
	// ********************************
	task automatic tally_and_finish();
		if (err_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one apb transfer; ready, data and error taken at the same edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (PREADY_O !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			tally_and_finish();
		end
		rd = PRDATA_O;
		er = PSLVERR_O;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic edges(input logic [7:0] ctl);
		logic p;
		apb(1'b1, tscp_pkg::CTRL_OFS, {24'h0, ctl});
		repeat (40) @(negedge clk);
		c = 0;
		p = SPCLK_O;
		repeat (1000) begin
			@(negedge clk);
			if (SPCLK_O === 1'b1 && p === 1'b0) c++;
			p = SPCLK_O;
		end
	endtask : edges

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset();
		chk("line oe", STREAM_OE_N_O, 8'hff);
		chk("clk oe", SPCLK_OE_N_O, 1'b1);
		apb(1'b0, tscp_pkg::DIR_OFS + 12'h1fc, 32'h0);
		chk("dir127", rd, 32'h0);
		apb(1'b0, tscp_pkg::CTRL_OFS, 32'h0);
		chk("ctrl", rd, 32'h0);
	endtask : t_reset

	// 20 us window at 244 ns per period gives about 82 edges
	task automatic t_clock();
		edges(8'h60);
		chk("oe two", SPCLK_OE_N_O, 1'b0);
		chk("frame oe two", foe, 1'b0);
		chk("rate two", c >= 78 && c <= 86, 1'b1);
		apb(1'b0, tscp_pkg::STAT_OFS, 32'h0);
		chk("active", rd[11], 1'b1);
		en1 <= 1'b0;
		en2 <= 1'b0;
		edges(8'h50);
		chk("internal", c >= 78 && c <= 86, 1'b1);
		en2 <= 1'b1;
		edges(8'h60);
		chk("ref one off", c, 0);
		edges(8'h80);
		chk("three two", c >= 78 && c <= 86, 1'b1);
		chk("oe three", SPCLK_OE_N_O, 1'b0);
		en1 <= 1'b1;
		edges(8'hc0);
		chk("oe four", SPCLK_OE_N_O, 1'b1);
		chk("lines four", STREAM_OE_N_O, 8'hff);
		edges(8'h08);
		chk("oe one", SPCLK_OE_N_O, 1'b1);
		chk("frame oe one", foe, 1'b1);
		chk("high lines", STREAM_OE_N_O[7:4], 4'hf);
	endtask : t_clock

	task automatic t_regs();
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped err", er, 1'b1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 12'h102, 32'hff);
		chk("unaligned err", er, 1'b1);
		apb(1'b1, tscp_pkg::DIR_OFS + 12'h014, 32'h1a5);
		apb(1'b0, tscp_pkg::DIR_OFS + 12'h014, 32'h0);
		chk("dir5", rd, 32'ha5);
		chk("dir ok", er, 1'b0);
	endtask : t_regs

	// the buffer fills while channels drain it slowly, until it has room for a word again
	task automatic t_buffer();
		int n;
		apb(1'b1, tscp_pkg::CTRL_OFS, 32'h0);
		@(posedge clk);
		txv <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (TX_READY_O !== 1'b0 && n < 50);
		chk("refused", TX_READY_O, 1'b0);
		if (n >= 50) tally_and_finish();
		@(posedge clk);
		txv <= 1'b0;
		apb(1'b0, tscp_pkg::STAT_OFS, 32'h0);
		chk("full", rd[12], 1'b1);
		chk("chan range", rd[6:0] <= tscp_pkg::CMAX_2M, 1'b1);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (RX_VALID_O !== 1'b1 && n < 3000);
		chk("rx word", RX_VALID_O, 1'b1);
		if (n >= 3000) tally_and_finish();
		n = 0;
		while (TX_READY_O !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk("drained", TX_READY_O, 1'b1);
		if (n >= 3000) tally_and_finish();
	endtask : t_buffer

	initial begin
		clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; en1 = 1'b1; en2 = 1'b1; txv = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_clock();
		t_regs();
		t_buffer();
		tally_and_finish();
	end
endmodule : tb
